/* File: verilog/servo_fault_reaction_unit.sv */
/*
 * Fault supervision and reaction for a servo amplifier, codes 05..17.
 * Assumes fault flags, enables, position flag and acknowledge come from
 * pins or other clocks and are synchronised here.
 */
`timescale 1ns/1ps
module servo_fault_reaction_unit
    import fault_pkg::*;
#(
    parameter int REFRESH_CYCLES = REFRESH_CYCLES_DEF
)
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic OVERCURRENT,
    input wire logic [N_OTHER-1:0] OTHER_FAULTS,
    input wire logic SW_ENABLE,
    input wire logic HW_ENABLE,
    input wire logic INPUT_OVERCURRENT,
    input wire logic POS_OUT_OF_RANGE,
    input wire logic ERROR_ACK,
    output logic [7:0] ERROR_CODE,
    output logic POWER_DISABLE,
    output logic MAX_TORQUE_STOP,
    output logic LOCKED,
    output logic DISP_F,
    output logic [3:0] DISP_TENS,
    output logic [3:0] DISP_ONES,
    output logic DISP_STROBE
);
    localparam logic [REFRESH_CNT_W-1:0] REFRESH_LAST =
        REFRESH_CNT_W'(REFRESH_CYCLES - 1);

    // lowest pending slot wins the code: it is also the lowest number
    function automatic logic [7:0] pick_code(logic [N_FAULTS-1:0] p);
        logic [7:0] c;
        c = NO_CODE;
        for (int i = N_FAULTS - 1; i >= 0; i--) begin
            if (p[i]) begin
                c = FIRST_CODE + 8'(i);
            end
        end
        return c;
    endfunction

    // decimal split of a two-digit code, tens in the upper nibble
    function automatic logic [7:0] to_digits(logic [7:0] c);
        logic [7:0] t;
        logic [7:0] o;
        t = c / TEN;
        o = c % TEN;
        return {t[3:0], o[3:0]};
    endfunction

    fault_if flt ();

    logic [N_RAW-1:0] raw;
    logic [N_RAW-1:0] sync1;
    logic [N_RAW-1:0] sync2;
    logic ack_d;
    logic oc_s;
    logic [N_OTHER-1:0] other_s;
    logic sw_en_s;
    logic hw_en_s;
    logic in_oc_s;
    logic pos_out_s;
    logic ack_s;
    logic ack_pulse;
    logic armed;
    logic next_armed;
    logic any_pending;
    logic immediate;
    logic next_torque_stop;
    logic [7:0] next_code;
    logic [7:0] digits;
    lock_state_e state;
    lock_state_e next_state;
    logic [REFRESH_CNT_W-1:0] refresh_cnt;
    logic [REFRESH_CNT_W-1:0] next_refresh_cnt;
    logic tick;

    // every outside level passes two flops before anything reads it
    assign raw = {ERROR_ACK, POS_OUT_OF_RANGE, INPUT_OVERCURRENT, HW_ENABLE,
                  SW_ENABLE, OTHER_FAULTS, OVERCURRENT};

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            sync1 <= SYNC_RESET;
            sync2 <= SYNC_RESET;
            ack_d <= 1'b0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            ack_d <= sync2[N_RAW-1];
        end
    end

    // unpack the synchronised bundle
    assign oc_s = sync2[0];
    assign other_s = sync2[N_OTHER:1];
    assign sw_en_s = sync2[N_OTHER+1];
    assign hw_en_s = sync2[N_OTHER+2];
    assign in_oc_s = sync2[N_OTHER+3];
    assign pos_out_s = sync2[N_OTHER+4];
    assign ack_s = sync2[N_RAW-1];
    assign ack_pulse = ack_s & ~ack_d; // one acknowledge per press

    // fault causes per slot, packed by one driver in slot order
    logic cause_oc;
    logic cause_hwen;
    logic cause_inoc;
    logic cause_limit;
    assign cause_oc = oc_s;
    assign cause_hwen = sw_en_s & ~hw_en_s;
    assign cause_inoc = in_oc_s;
    // a trip disarms monitoring, so the operator can ack while still out
    assign cause_limit = armed & pos_out_s;
    assign flt.cause = {cause_limit, cause_inoc, cause_hwen, other_s,
                        cause_oc};
    assign flt.ack = ack_pulse;

    fault_latch u_latch (
        .clk(SYS_CLK),
        .nrst(NRST),
        .f(flt.latch)
    );

    // monitoring is off while outside, back on as soon as inside
    assign next_armed = ~pos_out_s;

    // reaction selection: power disable overrides the torque stop
    assign any_pending = |flt.pending;
    assign immediate = |(flt.pending & IMMEDIATE_MASK);
    assign next_torque_stop = flt.pending[IDX_SW_LIMIT] & ~immediate;
    assign next_code = pick_code(flt.pending);

    // lock follows the latches; they only clear through an acknowledge
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (any_pending) begin
                    next_state = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                if (!any_pending) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            armed <= 1'b1;
            state <= ST_RUN;
            LOCKED <= 1'b0;
            ERROR_CODE <= NO_CODE;
            POWER_DISABLE <= 1'b0;
            MAX_TORQUE_STOP <= 1'b0;
        end else begin
            armed <= next_armed;
            state <= next_state;
            LOCKED <= (next_state == ST_LOCKED);
            ERROR_CODE <= next_code;
            POWER_DISABLE <= immediate;
            MAX_TORQUE_STOP <= next_torque_stop;
        end
    end

    // one-second refresh; the display may lag a new code by up to a period
    assign tick = (refresh_cnt == REFRESH_LAST);
    assign next_refresh_cnt = tick ? REFRESH_CNT_RESET
                                   : refresh_cnt + REFRESH_CNT_W'(1);
    assign digits = to_digits(ERROR_CODE);

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            refresh_cnt <= REFRESH_CNT_RESET;
            DISP_STROBE <= 1'b0;
            DISP_F <= 1'b0;
            DISP_TENS <= DIGIT_RESET;
            DISP_ONES <= DIGIT_RESET;
        end else begin
            refresh_cnt <= next_refresh_cnt;
            DISP_STROBE <= tick;
            if (tick) begin
                DISP_F <= LOCKED;
                DISP_TENS <= digits[7:4];
                DISP_ONES <= digits[3:0];
            end
        end
    end

    AST_OC_DISABLE: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        flt.cause[IDX_OVERCURRENT] |=> ##1 (POWER_DISABLE &&
            ERROR_CODE == FIRST_CODE))
        else $error("overcurrent did not give code 05 and disable");
    AST_HWEN_DISABLE: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        (sw_en_s && !hw_en_s) |=> flt.pending[IDX_HW_ENABLE] ##1
            POWER_DISABLE)
        else $error("missing hardware enable did not remove power");
    AST_INOC_DISABLE: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        in_oc_s |=> ##1 POWER_DISABLE)
        else $error("input overcurrent did not disable power");
    AST_LIMIT_STOP: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        (flt.pending[IDX_SW_LIMIT] && !immediate) |=>
            (MAX_TORQUE_STOP && !POWER_DISABLE))
        else $error("limit trip did not stop at maximum torque");
    AST_REARM: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        (!armed && !pos_out_s) |=> armed)
        else $error("limit monitoring not rearmed inside range");
    AST_NO_RETRIP: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        (armed && pos_out_s) |=> (!armed && !flt.cause[IDX_SW_LIMIT]))
        else $error("limit tripped again while outside range");
    AST_STROBE_GAP: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        DISP_STROBE |=> !DISP_STROBE [*2])
        else $error("display refreshed too often");
    AST_DISP_F: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        DISP_STROBE |-> (DISP_F == $past(LOCKED)))
        else $error("display letter does not follow the lock");
    AST_LOCK_HOLD: assert property (
        @(posedge SYS_CLK) disable iff (!NRST)
        (LOCKED && !$past(ack_pulse)) |=> LOCKED)
        else $error("lock released without acknowledge");

    COV_OC: cover property (@(posedge SYS_CLK) disable iff (!NRST)
        $rose(POWER_DISABLE) && ERROR_CODE == FIRST_CODE);
    COV_LIMIT: cover property (@(posedge SYS_CLK) disable iff (!NRST)
        $rose(MAX_TORQUE_STOP));
    COV_UNLOCK: cover property (@(posedge SYS_CLK) disable iff (!NRST)
        $fell(LOCKED));
    COV_SHOW: cover property (@(posedge SYS_CLK) disable iff (!NRST)
        DISP_STROBE && DISP_F);
endmodule // servo_fault_reaction_unit

/* File: verilog/fault_pkg.sv */
/*
 * Constants, codes and types for the servo fault reaction unit.
 * Assumes a 100 MHz system clock and fault flags already qualified
 * by the power stage, the encoder logic and position supervision.
 */
// Functional notes
// - output current above 2.5x rated: record code 05, disable motor power
// - software enable without hardware enable: record code 15, remove power
// - power input overcurrent: record code 16, disable motor power
// - software limit trip outside range: code 17, stop at maximum torque
// - limit monitoring rearms itself once position is back in range
// - while an error pends, show F and two digits, refreshed each second
// - after a fault reaction stay locked until the operator acknowledges
package fault_pkg;
    // fault slots: slot index is the error number minus FIRST_CODE
    localparam int N_FAULTS = 13;
    localparam int N_OTHER = 9;
    localparam int IDX_OVERCURRENT = 0;
    localparam int IDX_OTHER_LO = 1;
    localparam int IDX_OTHER_HI = 9;
    localparam int IDX_HW_ENABLE = 10;
    localparam int IDX_INPUT_OC = 11;
    localparam int IDX_SW_LIMIT = 12;
    localparam logic [7:0] FIRST_CODE = 8'h05;
    localparam logic [7:0] NO_CODE = 8'h00;
    localparam logic [7:0] TEN = 8'h0A;
    // slots whose reaction is an immediate power disable
    localparam logic [N_FAULTS-1:0] IMMEDIATE_MASK = 13'h0FFF;
    localparam logic [N_FAULTS-1:0] PENDING_RESET = 13'h0000;
    localparam logic [N_FAULTS-1:0] NO_FAULTS = 13'h0000;
    // raw pin bundle width: overcurrent, others, enables, input oc, pos, ack
    localparam int N_RAW = 15;
    localparam logic [N_RAW-1:0] SYNC_RESET = 15'h0000;
    // display refresh timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int REFRESH_PERIOD_MS = 1000;
    localparam int NS_PER_MS = 1000000;
    localparam int REFRESH_CYCLES_DEF =
        REFRESH_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int REFRESH_CNT_W = 27;
    localparam logic [REFRESH_CNT_W-1:0] REFRESH_CNT_RESET = 27'h0000000;
    localparam logic [3:0] DIGIT_RESET = 4'h0;

    typedef enum logic {
        ST_RUN = 1'b0,
        ST_LOCKED = 1'b1
    } lock_state_e;
endpackage

/* File: verilog/fault_if.sv */
/*
 * Carrier between the fault controller and its latch bank.
 * Assumes both ends share SYS_CLK and NRST.
 */
`timescale 1ns/1ps
interface fault_if;
    import fault_pkg::*;
    logic [N_FAULTS-1:0] cause;
    logic ack;
    logic [N_FAULTS-1:0] pending;
    modport latch (input cause, input ack, output pending);
    modport ctrl (output cause, output ack, input pending);
endinterface

/* File: verilog/fault_latch.sv */
/*
 * Sticky latch bank, one bit per fault slot.
 * Assumes cause is a synchronous level and ack a one-cycle pulse.
 */
`timescale 1ns/1ps
module fault_latch
    import fault_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    fault_if.latch f
);
    logic [N_FAULTS-1:0] next_pending;
    logic [N_FAULTS-1:0] clear_ok;

    // a bit clears only on ack with its cause gone; a set always wins
    assign clear_ok = {N_FAULTS{f.ack}} & ~f.cause;
    assign next_pending = (f.pending & ~clear_ok) | f.cause;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            f.pending <= PENDING_RESET;
        end else begin
            f.pending <= next_pending;
        end
    end

    logic [N_FAULTS-1:0] keep;
    assign keep = f.pending & ~clear_ok;

    AST_LATCH_HOLD: assert property (
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> ((f.pending & $past(keep)) == $past(keep)))
        else $error("latched fault lost without acknowledge");
    AST_LATCH_SET: assert property (
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> ((f.pending & $past(f.cause)) == $past(f.cause)))
        else $error("fault cause not latched");
endmodule // fault_latch

/* File: dv/ack_operator.sv */
/*
 * Operator model: turns a one-cycle press request into an acknowledge.
 * Assumes press is driven just after the rising edge of clk.
 */
`timescale 1ns/1ps
module ack_operator (
    input wire logic clk,
    input wire logic press,
    output logic ack
);
    logic [2:0] hold = 3'h0;

    // held four cycles so both sync flops surely see the level
    always @(posedge clk) begin
        if (press) begin
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    assign ack = (hold != 3'h0);
endmodule // ack_operator

/* File: dv/test_servo_fault_reaction_unit.sv */
/*
 * Bench: table of single and stacked faults, then refused
 * acknowledge, limit rearm, reset and display refresh cases.
 * Assumes a shortened REFRESH_CYCLES of 8.
 */
`timescale 1ns/1ps
module test_servo_fault_reaction_unit;
    import fault_pkg::*;
    typedef struct {
        logic [12:0] stim;
        logic [7:0] code;
        logic pd;
        logic mts;
    } row_s;
    localparam int RC = 8;
    logic SYS_CLK = 1'b0;
    logic NRST = 1'b0;
    logic OVERCURRENT = 1'b0;
    logic [N_OTHER-1:0] OTHER_FAULTS = 9'h000;
    logic SW_ENABLE = 1'b0;
    logic HW_ENABLE = 1'b1;
    logic INPUT_OVERCURRENT = 1'b0;
    logic POS_OUT_OF_RANGE = 1'b0;
    logic ERROR_ACK;
    logic press = 1'b0;
    logic [7:0] ERROR_CODE;
    logic POWER_DISABLE, MAX_TORQUE_STOP, LOCKED, DISP_F, DISP_STROBE;
    logic [3:0] DISP_TENS, DISP_ONES;
    int mismatches = 0;
    int total_checks = 0;
    int n;
    row_s rows [14];

    always #5 SYS_CLK = ~SYS_CLK;

    ack_operator op (.clk(SYS_CLK), .press(press), .ack(ERROR_ACK));

    servo_fault_reaction_unit #(.REFRESH_CYCLES(RC)) dut (
        .SYS_CLK(SYS_CLK), .NRST(NRST), .OVERCURRENT(OVERCURRENT),
        .OTHER_FAULTS(OTHER_FAULTS), .SW_ENABLE(SW_ENABLE),
        .HW_ENABLE(HW_ENABLE), .INPUT_OVERCURRENT(INPUT_OVERCURRENT),
        .POS_OUT_OF_RANGE(POS_OUT_OF_RANGE), .ERROR_ACK(ERROR_ACK),
        .ERROR_CODE(ERROR_CODE), .POWER_DISABLE(POWER_DISABLE),
        .MAX_TORQUE_STOP(MAX_TORQUE_STOP), .LOCKED(LOCKED),
        .DISP_F(DISP_F), .DISP_TENS(DISP_TENS), .DISP_ONES(DISP_ONES),
        .DISP_STROBE(DISP_STROBE)
    );

    task automatic complete_run;
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // sample one step after the edge so its updates have landed
    task automatic tick(input int k);
        repeat (k) @(posedge SYS_CLK);
        #1;
    endtask

    // slot index picks the pin; slot 10 also drops the hardware enable
    task automatic drive(input logic [12:0] s);
        @(posedge SYS_CLK);
        OVERCURRENT <= s[0];
        OTHER_FAULTS <= s[9:1];
        SW_ENABLE <= s[10];
        HW_ENABLE <= ~s[10];
        INPUT_OVERCURRENT <= s[11];
        POS_OUT_OF_RANGE <= s[12];
    endtask

    task automatic wait_code(input logic [7:0] c);
        n = 0;
        while (ERROR_CODE !== c && n < 20) begin
            tick(1);
            n++;
        end
        chk(ERROR_CODE, c);
    endtask

    // long low gap after the pulse keeps presses apart for the sync
    task automatic press_ack;
        @(posedge SYS_CLK);
        press <= 1'b1;
        @(posedge SYS_CLK);
        press <= 1'b0;
        tick(10);
    endtask

    task automatic wait_strobe;
        n = 0;
        while (DISP_STROBE !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
    endtask

    // skip a strobe at this very edge: it caught values from before it
    task automatic disp(input logic [7:0] c);
        tick(1);
        wait_strobe();
        tick(2);
        chk(8'(DISP_F), 8'(c != 8'h00));
        chk(8'(DISP_TENS), c / 8'h0A);
        chk(8'(DISP_ONES), c % 8'h0A);
    endtask

    // a hang counts as a failure
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end

    initial begin
        for (int i = 0; i < 13; i++) begin
            rows[i].stim = 13'h0001 << i;
            rows[i].code = FIRST_CODE + 8'(i);
            rows[i].pd = (i < 12);
            rows[i].mts = (i == 12);
        end
        // stacked faults: lowest code wins, disable beats torque stop
        rows[13] = '{13'h1801, 8'h05, 1'b1, 1'b0};
        tick(19);
        chk(ERROR_CODE, 8'h00); // RESET
        chk(8'({POWER_DISABLE, MAX_TORQUE_STOP, LOCKED}), 8'h00); // RESET
        @(posedge SYS_CLK);
        NRST <= 1'b1;
        tick(2);
        foreach (rows[r]) begin
            drive(rows[r].stim);
            wait_code(rows[r].code);
            chk(8'(POWER_DISABLE), 8'(rows[r].pd));
            chk(8'(MAX_TORQUE_STOP), 8'(rows[r].mts));
            chk(8'(LOCKED), 8'h01);
            disp(rows[r].code);
            drive(13'h0000);
            tick(4);
            chk(ERROR_CODE, rows[r].code);
            press_ack();
            chk(ERROR_CODE, 8'h00);
            chk(8'(LOCKED), 8'h00);
        end
        // acknowledge while the cause stands is refused
        drive(13'h0001);
        wait_code(8'h05);
        press_ack();
        chk(ERROR_CODE, 8'h05);
        chk(8'(LOCKED), 8'h01);
        drive(13'h0000);
        press_ack();
        chk(ERROR_CODE, 8'h00);
        // limit cleared while outside must not retrip until back inside
        drive(13'h1000);
        wait_code(8'h11);
        press_ack();
        chk(ERROR_CODE, 8'h00);
        drive(13'h0000);
        tick(3);
        drive(13'h1000);
        wait_code(8'h11);
        drive(13'h0000);
        press_ack();
        // reset in mid-run drops a latched fault and all outputs at once
        drive(13'h0001);
        wait_code(8'h05);
        @(posedge SYS_CLK);
        NRST <= 1'b0;
        drive(13'h0000);
        tick(1);
        chk(ERROR_CODE, 8'h00); // RESET
        chk(8'({POWER_DISABLE, MAX_TORQUE_STOP, LOCKED}), 8'h00); // RESET
        @(posedge SYS_CLK);
        NRST <= 1'b1;
        tick(4);
        chk(ERROR_CODE, 8'h00); // RESET
        chk(8'(LOCKED), 8'h00);
        disp(8'h00);
        wait_strobe();
        chk(8'(n), 8'(RC - 2));
        complete_run();
    end
endmodule // test_servo_fault_reaction_unit
